// File: design/exec_pkg.sv
package exec_pkg;

    // Bus map, byte addresses of one aligned word each
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_SP = 8'h08;
    localparam logic [7:0] OFF_INSTR = 8'h0C;
    localparam logic [7:0] OFF_SKIP = 8'h10;
    localparam logic [7:0] OFF_CYCLES = 8'h14;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h18;
    localparam logic [7:0] OFF_MEM_DATA = 8'h1C;

    // Status register layout
    localparam int STAT_Z_BIT = 2;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_MSB = 7;
    localparam int PAGE_W = 3;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [31:0] CYCLES_RST = 32'h0000_0000;
    localparam logic [8:0] MEM_ADDR_RST = 9'h000;

    // Data memory geometry
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 512;

    // Opcode fields
    localparam logic [7:0] OPC_OR_IMM = 8'h7D;
    localparam logic [7:0] OPC_PUSH_IMM = 8'h74;
    localparam logic [12:0] OPC_PAGE = 13'h0002;
    localparam logic [6:0] OPC_POP = 7'h23;
    localparam logic [6:0] OPC_PUSH_FR = 7'h22;

    // Fixed step counts
    localparam logic [15:0] SP_STEP = 16'h0001;
    localparam logic [31:0] CYCLE_STEP = 32'h0000_0001;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// File: design/op_decode.sv
`timescale 1ns/1ps
`default_nettype none

module op_decode
    import exec_pkg::*;
(
    input wire logic [15:0] instr,
    output logic is_or_imm,
    output logic is_page,
    output logic is_pop,
    output logic is_push_fr,
    output logic is_push_imm
);

    // Opcode pattern matches
    assign is_or_imm = (instr[15:8] == OPC_OR_IMM); // RULE1
    assign is_page = (instr[15:3] == OPC_PAGE); // RULE3
    assign is_pop = (instr[15:9] == OPC_POP); // RULE7
    assign is_push_fr = (instr[15:9] == OPC_PUSH_FR); // RULE8
    assign is_push_imm = (instr[15:8] == OPC_PUSH_IMM); // RULE9

endmodule // op_decode

`default_nettype wire

// File: design/or_page_push_pop_exec.sv
// Overview of operation
// RULE1 - OR immediate into accumulator, one cycle
// RULE2 - OR result sets zero flag only
// RULE3 - Page field copied into status bits 7:5
// RULE4 - Page bits steer later jumps and calls
// RULE5 - True skip over page skips two, three cycles
// RULE6 - Skip runs over all pages plus next
// RULE7 - Pop: increment pointer, copy byte to operand
// RULE8 - Push operand: store at pointer, then decrement
// RULE9 - Push immediate: store at pointer, then decrement
// RULE10 - Data stack separate from call stack
// RULE11 - Push, pop, page leave other flags alone
`timescale 1ns/1ps
`default_nettype none

module or_page_push_pop_exec
    import exec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [PAGE_W-1:0] program_page_bits,
    output logic skip_active
);

    // Bus phase state
    logic ph_act_ff;
    logic ph_write_ff;
    logic [7:0] ph_addr_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic hresp_ff;

    // Core state
    // Accumulator, status, pointer and the last word seen
    logic [7:0] acc_ff;
    logic [7:0] status_ff;
    logic [15:0] sp_ff;
    logic [15:0] instr_ff;
    logic skip_armed_ff;
    logic [31:0] cycles_ff;
    logic [MEM_AW-1:0] mem_addr_ff;
    logic [7:0] data_mem [0:MEM_DEPTH-1];

    // Next values
    // Each one is chosen by the continuous assignments below, except nxt_status, set in an always_comb
    logic [7:0] nxt_acc;
    logic [7:0] nxt_status;
    logic [15:0] nxt_sp;
    logic nxt_skip_armed;
    logic [31:0] nxt_cycles;
    logic nxt_ph_act;
    logic nxt_hreadyout;

    // Register offset match for the latched data phase address
    function automatic logic reg_hit(input logic [7:0] addr,
        input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // Bus phase decode; a transfer starts only on NONSEQ with hready
    wire addr_take = hsel & (htrans == HTRANS_NONSEQ) & hready;
    wire rd_fetch = ph_act_ff & ~ph_write_ff & ~hreadyout_ff;
    wire wr_go = ph_act_ff & ph_write_ff & hreadyout_ff;

    // Register selects, shared by write strobes and read mux
    wire sel_acc = reg_hit(ph_addr_ff, OFF_ACC);
    wire sel_status = reg_hit(ph_addr_ff, OFF_STATUS);
    wire sel_sp = reg_hit(ph_addr_ff, OFF_SP);
    wire sel_instr = reg_hit(ph_addr_ff, OFF_INSTR);
    wire sel_skip = reg_hit(ph_addr_ff, OFF_SKIP);
    wire sel_cycles = reg_hit(ph_addr_ff, OFF_CYCLES);
    wire sel_mem_addr = reg_hit(ph_addr_ff, OFF_MEM_ADDR);
    wire sel_mem_data = reg_hit(ph_addr_ff, OFF_MEM_DATA);

    // Write strobes, one per register, in the write data phase
    wire wr_acc = wr_go & sel_acc;
    wire wr_status = wr_go & sel_status;
    wire wr_sp = wr_go & sel_sp;
    wire wr_instr = wr_go & sel_instr;
    wire wr_skip = wr_go & sel_skip;
    wire wr_cycles = wr_go & sel_cycles;
    wire wr_mem_addr = wr_go & sel_mem_addr;
    wire wr_mem_data = wr_go & sel_mem_data;

    // Instruction fields, taken straight from the write data
    // The word runs in its own data phase, so no fetch stage
    // sits between the bus and the execute logic
    wire [15:0] op = hwdata[15:0];
    wire [7:0] immediate_byte = op[7:0];
    wire [MEM_AW-1:0] file_register_operand = op[MEM_AW-1:0];
    wire [PAGE_W-1:0] page_field = op[PAGE_W-1:0];

    wire is_or_imm;
    wire is_page;
    wire is_pop;
    wire is_push_fr;
    wire is_push_imm;

    op_decode i_op_decode (
        .instr(op),
        .is_or_imm(is_or_imm),
        .is_page(is_page),
        .is_pop(is_pop),
        .is_push_fr(is_push_fr),
        .is_push_imm(is_push_imm)
    );

    // Skip handling: a true skip swallows pages and one more
    // A swallowed word still costs its cycle; a swallowed page
    // word keeps the skip open for the word after it
    wire exec_go = wr_instr;
    wire exec_skipped = exec_go & skip_armed_ff;
    wire exec_run = exec_go & ~skip_armed_ff;
    wire skip_keeps = exec_skipped & is_page; // RULE6

    // Accumulator OR and zero flag
    wire [7:0] or_result = acc_ff | immediate_byte; // RULE1
    wire or_zero = (or_result == 8'h00); // RULE2
    wire do_or = exec_run & is_or_imm;
    wire do_page = exec_run & is_page;

    // Data stack pointer arithmetic
    wire [15:0] sp_inc = sp_ff + SP_STEP;
    wire [15:0] sp_dec = sp_ff - SP_STEP;
    wire do_pop = exec_run & is_pop;
    wire do_push_fr = exec_run & is_push_fr;
    wire do_push_imm = exec_run & is_push_imm;

    // Data memory reads for stack moves
    // Only the low pointer bits address the memory, so the
    // stack wraps inside it with no warning
    wire [7:0] pop_byte = data_mem[sp_inc[MEM_AW-1:0]]; // RULE7
    wire [7:0] fr_byte = data_mem[file_register_operand]; // RULE8

    // One data memory write port shared by bus and stack moves
    // The bus carries one write per cycle, so a bus store and a
    // stack move never meet in the same cycle
    wire mem_we = wr_mem_data | do_pop | do_push_fr | do_push_imm;
    wire [MEM_AW-1:0] mem_wa = do_pop ? file_register_operand : // RULE7
        (do_push_fr | do_push_imm) ? sp_ff[MEM_AW-1:0] : // RULE8 RULE9
        mem_addr_ff;
    wire [7:0] mem_wd = do_pop ? pop_byte :
        do_push_fr ? fr_byte : // RULE8
        do_push_imm ? immediate_byte : // RULE9
        hwdata[7:0];

    // Next accumulator
    // Only the OR word or a bus write touches it
    assign nxt_acc = do_or ? or_result : // RULE1
        wr_acc ? hwdata[7:0] : acc_ff;

    // Next status: only zero flag on OR, only page bits on page
    // Stack moves fall through and keep every flag
    // A bus write replaces the whole byte
    always_comb begin
        nxt_status = status_ff; // RULE11
        if (wr_status) begin
            nxt_status = hwdata[7:0];
        end else if (do_or) begin
            nxt_status[STAT_Z_BIT] = or_zero; // RULE2
        end else if (do_page) begin
            nxt_status[PAGE_MSB:PAGE_LSB] = page_field; // RULE3
        end
    end

    // Next pointer: pop pre-increments, pushes post-decrement
    // Pointer moves never touch a call stack; none lives here
    assign nxt_sp = do_pop ? sp_inc : // RULE7
        (do_push_fr | do_push_imm) ? sp_dec : // RULE8 RULE9
        wr_sp ? hwdata[15:0] : sp_ff;

    // Next skip state; each skipped page keeps the skip open
    // Any other swallowed word closes it
    assign nxt_skip_armed = wr_skip ? hwdata[0] : // RULE5
        exec_skipped ? skip_keeps : skip_armed_ff; // RULE6

    // Cycle count: one per skip, executed or skipped word
    assign nxt_cycles = (wr_skip & hwdata[0]) | exec_go ?
        cycles_ff + CYCLE_STEP : // RULE5 RULE6
        wr_cycles ? hwdata : cycles_ff;

    // Bus phase sequencing; reads take one wait state
    // The wait gives the read mux a full cycle before the data
    // is registered, writes finish with no wait
    assign nxt_ph_act = addr_take | (ph_act_ff & ~hreadyout_ff);
    assign nxt_hreadyout = addr_take ? hwrite :
        rd_fetch ? 1'b1 : hreadyout_ff;

    // Read values, narrow registers zero-extended to a word
    wire [31:0] rd_acc = {24'h000000, acc_ff};
    wire [31:0] rd_status = {24'h000000, status_ff};
    wire [31:0] rd_sp = {16'h0000, sp_ff};
    wire [31:0] rd_instr = {16'h0000, instr_ff};
    wire [31:0] rd_skip = {31'h0000_0000, skip_armed_ff};
    wire [31:0] rd_mem_addr = {23'h000000, mem_addr_ff};
    wire [31:0] rd_mem_data = {24'h000000, data_mem[mem_addr_ff]};

    // Read mux for the data phase; unmapped offsets read zero
    wire [31:0] rd_mux = sel_acc ? rd_acc :
        sel_status ? rd_status :
        sel_sp ? rd_sp :
        sel_instr ? rd_instr :
        sel_skip ? rd_skip :
        sel_cycles ? cycles_ff :
        sel_mem_addr ? rd_mem_addr :
        sel_mem_data ? rd_mem_data :
        32'h0000_0000;

    // Bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_act_ff <= 1'b0;
            ph_write_ff <= 1'b0;
            ph_addr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
        end else begin
            ph_act_ff <= nxt_ph_act;
            hreadyout_ff <= nxt_hreadyout;
            if (addr_take) begin
                ph_write_ff <= hwrite;
                ph_addr_ff <= haddr[7:0];
            end
        end
    end

    // Read data and response; data loads only in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
            hresp_ff <= HRESP_OKAY;
        end else begin
            hresp_ff <= HRESP_OKAY;
            if (rd_fetch) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // Core registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= ACC_RST;
            status_ff <= STATUS_RST;
            sp_ff <= SP_RST;
            instr_ff <= INSTR_RST;
            mem_addr_ff <= MEM_ADDR_RST;
        end else begin
            acc_ff <= nxt_acc;
            status_ff <= nxt_status;
            sp_ff <= nxt_sp;
            if (exec_go) begin
                instr_ff <= op;
            end
            if (wr_mem_addr) begin
                mem_addr_ff <= hwdata[MEM_AW-1:0];
            end
        end
    end

    // Skip state and cycle count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_armed_ff <= 1'b0;
            cycles_ff <= CYCLES_RST;
        end else begin
            skip_armed_ff <= nxt_skip_armed;
            cycles_ff <= nxt_cycles;
        end
    end

    // Data memory holds the data stack; no call stack lives here
    // No reset: contents are unknown until software writes them
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            data_mem[mem_wa] <= mem_wd; // RULE10
        end
    end

    // Outputs straight from flops
    // The page port mirrors the status bits for jump logic
    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign program_page_bits = status_ff[PAGE_MSB:PAGE_LSB]; // RULE4
    assign skip_active = skip_armed_ff;

endmodule // or_page_push_pop_exec

`default_nettype wire

// File: tb/or_page_push_pop_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module or_page_push_pop_exec_monitor
    import exec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [PAGE_W-1:0] program_page_bits,
    input wire logic skip_active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Address phase taken, instruction data phase
    logic taken;
    logic instr_ff;
    logic is_pg;
    assign taken = hsel && htrans == HTRANS_NONSEQ && hready;
    assign is_pg = instr_ff && hwdata[15:3] == OPC_PAGE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_ff <= 1'b0;
        end else if (hready) begin
            instr_ff <= taken && hwrite && haddr[7:0] == OFF_INSTR;
        end
    end
    AST_PAGE_SET: assert property (is_pg && !skip_active |=>
        program_page_bits == $past(hwdata[2:0])) else $error("page not set");
    AST_PAGE_KEEP: assert property (instr_ff && !is_pg |=>
        $stable(program_page_bits)) else $error("page moved");
    AST_SKIP_ARMED: assert property (is_pg && skip_active |=>
        skip_active) else $error("skip dropped on page");
    AST_SKIP_NOEXEC: assert property (is_pg && skip_active |=>
        $stable(program_page_bits)) else $error("skipped page ran");
    AST_SKIP_END: assert property (instr_ff && !is_pg && skip_active
        |=> !skip_active) else $error("skip not ended");
    AST_RD_WAIT: assert property (taken && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait wrong");
    AST_WR_FAST: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("bad response");
endmodule // or_page_push_pop_exec_monitor

bind or_page_push_pop_exec or_page_push_pop_exec_monitor i_mon (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .program_page_bits, .skip_active);

`default_nettype wire

// File: tb/or_page_push_pop_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module or_page_push_pop_exec_bench;
    import exec_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [PAGE_W-1:0] pg;
    logic skp;
    logic [31:0] r;
    int num_errors = 0;
    int num_checks = 0;

    or_page_push_pop_exec i_or_page_push_pop_exec (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .program_page_bits(pg), .skip_active(skp));

    // Clock
    always #5 hclk = ~hclk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask

    // Edge at which hready is high, bounded
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
    endtask

    // One single AHB transfer
    task automatic xf(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    // OR immediate, zero flag, other flags kept
    task automatic t_or();
        xf(1'b1, OFF_STATUS, 32'hFB);
        xf(1'b1, OFF_ACC, 32'h0);
        xf(1'b1, OFF_INSTR, 32'h7D00);
        rc(OFF_STATUS, 32'hFF);
        xf(1'b1, OFF_INSTR, 32'h7D5A);
        rc(OFF_ACC, 32'h5A);
        rc(OFF_STATUS, 32'hFB);
    endtask

    // Push operand, push immediate, pop
    task automatic t_stack();
        xf(1'b1, OFF_SP, 32'h10);
        xf(1'b1, OFF_MEM_ADDR, 32'h20);
        xf(1'b1, OFF_MEM_DATA, 32'h33);
        xf(1'b1, OFF_INSTR, 32'h4420);
        xf(1'b1, OFF_INSTR, 32'h74A5);
        rc(OFF_SP, 32'h0E);
        xf(1'b1, OFF_MEM_ADDR, 32'h10);
        rc(OFF_MEM_DATA, 32'h33);
        xf(1'b1, OFF_INSTR, 32'h4630);
        rc(OFF_SP, 32'h0F);
        xf(1'b1, OFF_MEM_ADDR, 32'h30);
        rc(OFF_MEM_DATA, 32'hA5);
        rc(OFF_STATUS, 32'hFB);
    endtask

    // Every page value reaches the port and status
    task automatic t_page();
        for (int n = 0; n < 8; n++) begin
            xf(1'b1, OFF_INSTR, 32'h10 | n);
            @(posedge hclk);
            chk({29'h0, pg}, n);
            rc(OFF_STATUS, {24'h0, n[2:0], 5'h1B});
        end
    endtask

    // True skip over one and two page words
    task automatic t_skip(input int np);
        xf(1'b1, OFF_CYCLES, 32'h0);
        xf(1'b1, OFF_SKIP, 32'h1);
        @(posedge hclk);
        chk({31'h0, skp}, 32'h1);
        for (int n = 0; n < np; n++)
            xf(1'b1, OFF_INSTR, 32'h12 + n);
        xf(1'b1, OFF_INSTR, 32'h7DFF);
        @(posedge hclk);
        chk({29'h0, pg, skp}, 32'hE);
        rc(OFF_ACC, 32'h5A);
        rc(OFF_CYCLES, np + 2);
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rc(OFF_SP, 32'h0);
        rc(8'h40, 32'h0);
        t_or();
        t_stack();
        t_page();
        t_skip(1);
        t_skip(2);
        give_verdict();
    end
endmodule // or_page_push_pop_exec_bench

`default_nettype wire
